/* File: rtl/spi_byte_shifter.sv */
// Purpose: transmit and receive shift registers of one byte
// Assumes: load, shift_out and sample are one-clock pulses
// Notes: mosi comes from a flip-flop and holds between shifts

`timescale 1ns/10ps

module spi_byte_shifter
	import spi_master_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic load,
	input wire logic [7:0] load_data,
	input wire logic shift_out,
	input wire logic sample,
	input wire logic miso,
	output logic mosi,
	output logic [7:0] rx_byte
);

	typedef struct packed {
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic mosi;
	} shift_state_s;

	shift_state_s r;
	shift_state_s r_nxt;

	// ****************************************************************
	// Shift paths; msb leaves first, new bits enter at the lsb
	// ****************************************************************
	always_comb begin
		r_nxt = r;
		if (clr) begin
			r_nxt = '0;
		end else begin
			if (load) begin
				r_nxt.tx_sh = load_data;
			end
			if (shift_out) begin
				r_nxt.mosi = r.tx_sh[7];
				r_nxt.tx_sh = {r.tx_sh[6:0], 1'b0};
			end
			if (sample) begin
				r_nxt.rx_sh = {r.rx_sh[6:0], miso};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign mosi = r.mosi;
	assign rx_byte = r.rx_sh;

endmodule

/* File: rtl/spi_clock_divider.sv */
// Purpose: half-period tick generator for the serial clock
// Assumes: run is held high for the whole time ticks are needed
// Notes: counter restarts from zero each time run rises

`timescale 1ns/10ps

module spi_clock_divider
	import spi_master_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic [1:0] div,
	output logic tick
);

	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} div_state_s;

	div_state_s r;
	div_state_s r_nxt;

	// ****************************************************************
	// Counter; tick marks the end of each half period
	// ****************************************************************
	always_comb begin
		r_nxt = r;
		r_nxt.tick = 1'b0;
		if (!run) begin
			r_nxt.cnt = 5'h00;
		end else if (r.cnt >= half_limit(div)) begin
			r_nxt.cnt = 5'h00;
			r_nxt.tick = 1'b1;
		end else begin
			r_nxt.cnt = r.cnt + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign tick = r.tick;

endmodule

/* File: rtl/spi_master_ctrl.sv */
// Purpose: register file, flags, interrupt and transfer sequencing
// Assumes: bus strobes are one clock long and synchronous to clk
// Notes: read data appears one clock after the read strobe

`timescale 1ns/10ps

// Summary of operation
// - Transmit-empty flag sets when holding byte is taken, clears on write.
// - Interrupt on transmit-empty rising while enabled and start is 1.
// - Transmit-empty and receive-full flags also drive output pins.
// - Receive-full flag sets on received byte, clears on register read.
// - Interrupt on receive-full rising while enabled and start is 0.
// - Status bits 1 and 0 always read as zero.
// - Master enable gates transfers and the interrupt; zero idles the master but keeps registers and flags.
// - Interrupt enable masks the request but keeps the pending cause.
// - Start high with a byte waiting begins shifting it out.
// - Every byte shifted in is stored in the receive holding register.
// - Bytes keep flowing while start stays high, back to back with select held low only for clock phase 1.
// - Divider code selects serial clock as clock over 4, 8, 16, 32.
// - Clock phase picks first or second edge for valid data.
// - Clock polarity sets the idle level of the serial clock while master enable is 1.
// - Sample edge bit selects falling or rising edge for incoming data.
// - Pending interrupt clears on transmit write or receive read.
module spi_master_ctrl
	import spi_master_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input spi_master_pkg::uc_req_s uc_req,
	output logic [7:0] uc_rdata,
	output logic irq_req_b,
	output logic tx_holding_empty,
	output logic rx_holding_full,
	output logic sck,
	output logic mosi,
	input wire logic miso,
	output logic [7:0] ss_b
);

	// ****************************************************************
	// State of the block
	// ****************************************************************
	typedef struct packed {
		master_control_s ctrl;
		logic [7:0] slave_sel;
		logic [7:0] tx_holding_reg;
		logic [7:0] rx_holding_reg;
		logic tx_holding_empty;
		logic rx_holding_full;
		logic int_pend;
		logic irq_req_b;
		logic [7:0] rdata;
		xfer_state_e state;
		logic [4:0] edge_cnt;
		logic [2:0] tick_cnt;
		logic byte_end;
		logic sck;
		logic [7:0] ss_b;
	} ctrl_state_s;

	ctrl_state_s r;
	ctrl_state_s r_nxt;

	// Strobes to the helpers, decided in the same clock
	logic div_run;
	logic tick;
	logic sh_clr;
	logic sh_load;
	logic sh_shift;
	logic sh_sample;
	logic [7:0] rx_byte;
	logic [7:0] status_word;

	// Bus decodes
	logic wr_ctrl;
	logic wr_sel;
	logic wr_tx;
	logic rd_rx;

	// Edge bookkeeping
	logic [4:0] edge_next;
	logic sck_next;
	logic go;
	logic tx_rise;
	logic rx_rise;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Divider only runs while a frame is on the wire, so each frame
	// starts on a clean half period
	spi_clock_divider u_div (
		.clk(clk),
		.rst_b(rst_b),
		.run(div_run),
		.div(r.ctrl.serial_clock_divider),
		.tick(tick)
	);

	spi_byte_shifter u_shift (
		.clk(clk),
		.rst_b(rst_b),
		.clr(sh_clr),
		.load(sh_load),
		.load_data(r.tx_holding_reg),
		.shift_out(sh_shift),
		.sample(sh_sample),
		.miso(miso),
		.mosi(mosi),
		.rx_byte(rx_byte)
	);

	// ****************************************************************
	// Bus decode and status word
	// ****************************************************************
	// One strobe meeting one register address; the same compare serves
	// every write decode and the receive read decode, so all of them treat the address alike
	function automatic logic reg_hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] target);
		reg_hit = strobe && (addr == target);
	endfunction

	assign wr_ctrl = reg_hit(uc_req.wr, uc_req.addr, ADDR_CONTROL);
	assign wr_sel = reg_hit(uc_req.wr, uc_req.addr, ADDR_SLAVE_SEL);
	assign wr_tx = reg_hit(uc_req.wr, uc_req.addr, ADDR_TX_HOLD);
	// Only the receive register has a read side effect
	assign rd_rx = reg_hit(uc_req.rd, uc_req.addr, ADDR_RX_HOLD);

	// Pending bit reads active low; bits 7, 6 and 1..0 read zero
	always_comb begin
		status_word = 8'h00;
		status_word[STAT_BUSY_BIT] = (r.state != ST_IDLE);
		status_word[STAT_INT_B_BIT] = !r.int_pend;
		status_word[STAT_TX_EMPTY_BIT] = r.tx_holding_empty;
		status_word[STAT_RX_FULL_BIT] = r.rx_holding_full;
	end

	// Serial edge arithmetic, valid when a tick arrives in the shift state
	// Even edge counts land the clock back on its idle level
	assign edge_next = r.edge_cnt + 5'h01;
	assign sck_next = r.ctrl.clock_polarity ^ edge_next[0];

	// Start request is a level: a byte waiting with start high.
	// The clock must already rest at its idle level; a polarity change
	// written together with start would otherwise move the clock in
	// the same edge as select and hand the slave a false edge.
	assign go = r.ctrl.master_enable && r.ctrl.start &&
		!r.tx_holding_empty && (r.sck == r.ctrl.clock_polarity);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		r_nxt = r;
		div_run = 1'b0;
		sh_clr = 1'b0;
		sh_load = 1'b0;
		sh_shift = 1'b0;
		sh_sample = 1'b0;
		tx_rise = 1'b0;
		rx_rise = 1'b0;
		r_nxt.byte_end = 1'b0;

		// Register writes
		if (wr_ctrl) begin
			r_nxt.ctrl = master_control_s'(uc_req.wdata);
		end
		if (wr_sel) begin
			r_nxt.slave_sel = uc_req.wdata;
		end

		// Transfer sequencing; while enabled, idle keeps the clock at its polarity and
		// select only rises again at the end of hold, so the slave never
		// sees an edge outside a frame
		unique case (r.state)
			ST_IDLE: begin
				r_nxt.sck = r.ctrl.clock_polarity &&
					r.ctrl.master_enable;
				r_nxt.ss_b = SS_IDLE;
				if (go) begin
					// Byte leaves the holding register here
					sh_load = 1'b1;
					tx_rise = 1'b1;
					r_nxt.tx_holding_empty = 1'b1;
					r_nxt.ss_b = ~r.slave_sel;
					r_nxt.tick_cnt = 3'h0;
					r_nxt.state = ST_SELECT;
				end
			end
			ST_SELECT: begin
				// Select leads the first clock edge by three half periods plus one clock
				div_run = 1'b1;
				if (tick) begin
					r_nxt.tick_cnt = r.tick_cnt + 3'h1;
					if (r.tick_cnt + 3'h1 == SEL_TICKS) begin
						// Phase 0 needs data out before edge one
						sh_shift = !r.ctrl.clock_phase;
						r_nxt.edge_cnt = 5'h00;
						r_nxt.state = ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				div_run = 1'b1;
				if (r.byte_end) begin
					// Byte's last sample (edge 15 or 16) is now in the shifter
					r_nxt.rx_holding_reg = rx_byte;
					r_nxt.rx_holding_full = 1'b1;
					rx_rise = !r.rx_holding_full;
					r_nxt.edge_cnt = 5'h00;
					if (go && r.ctrl.clock_phase) begin
						// Phase 1 keeps select low between bytes
						sh_load = 1'b1;
						tx_rise = 1'b1;
						r_nxt.tx_holding_empty = 1'b1;
					end else begin
						// Phase 0 must drop select; idle restarts
						r_nxt.tick_cnt = 3'h0;
						r_nxt.state = ST_HOLD;
					end
				end else if (tick && (r.edge_cnt != BYTE_EDGES)) begin
					r_nxt.edge_cnt = edge_next;
					r_nxt.sck = sck_next;
					// Odd edges lead for phase 1, even for phase 0
					sh_shift = (edge_next[0] == r.ctrl.clock_phase) &&
						(edge_next != BYTE_EDGES);
					sh_sample = (sck_next ==
						r.ctrl.rx_sample_edge);
					r_nxt.byte_end = (edge_next == BYTE_EDGES);
				end
			end
			ST_HOLD: begin
				// Clock parked, select held two periods after last edge
				div_run = 1'b1;
				r_nxt.sck = r.ctrl.clock_polarity;
				if (tick) begin
					r_nxt.tick_cnt = r.tick_cnt + 3'h1;
					if (r.tick_cnt + 3'h1 == HOLD_TICKS) begin
						r_nxt.ss_b = SS_IDLE;
						r_nxt.state = ST_IDLE;
					end
				end
			end
		endcase

		// Fresh byte from software; beats a same-cycle take, since the
		// taken byte is already in the shifter and this one is new
		if (wr_tx) begin
			r_nxt.tx_holding_reg = uc_req.wdata;
			r_nxt.tx_holding_empty = 1'b0;
			tx_rise = 1'b0;
		end

		// Read clears full unless a byte lands in the same cycle
		if (rd_rx && !(r.state == ST_SHIFT && r.byte_end)) begin
			r_nxt.rx_holding_full = 1'b0;
		end

		// Pending cause: clears on access, a new cause wins
		if (wr_tx || rd_rx) begin
			r_nxt.int_pend = 1'b0;
		end
		if (tx_rise && r.ctrl.start) begin
			r_nxt.int_pend = 1'b1;
		end
		if (rx_rise && !r.ctrl.start) begin
			r_nxt.int_pend = 1'b1;
		end

		// Disable drops any frame at once and parks the bus
		// Registers and flags survive, so software need not reload them
		if (!r.ctrl.master_enable) begin
			div_run = 1'b0;
			sh_clr = 1'b1;
			sh_load = 1'b0;
			sh_shift = 1'b0;
			sh_sample = 1'b0;
			r_nxt.state = ST_IDLE;
			r_nxt.byte_end = 1'b0;
			r_nxt.sck = 1'b0;
			r_nxt.ss_b = SS_IDLE;
		end

		// Request line masked, cause kept underneath
		r_nxt.irq_req_b = !(r_nxt.int_pend && r_nxt.ctrl.irq_enable &&
			r_nxt.ctrl.master_enable);

		// Read data registered; last value held between reads
		// Unmapped addresses read zero so probing sees no stale byte
		if (uc_req.rd) begin
			unique case (uc_req.addr)
				ADDR_STATUS: r_nxt.rdata = status_word;
				ADDR_CONTROL: r_nxt.rdata = r.ctrl;
				ADDR_SLAVE_SEL: r_nxt.rdata = r.slave_sel;
				ADDR_TX_HOLD: r_nxt.rdata = r.tx_holding_reg;
				ADDR_RX_HOLD: r_nxt.rdata = r.rx_holding_reg;
				default: r_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset spelled out field by field so the levels after reset are
	// plain to see; the transmit flag starts set because nothing waits
	// to be sent, and the selects start released
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			r.ctrl <= master_control_s'(CONTROL_RESET);
			r.slave_sel <= SLAVE_SEL_RESET;
			r.tx_holding_reg <= BYTE_RESET;
			r.rx_holding_reg <= BYTE_RESET;
			r.tx_holding_empty <= 1'b1;
			r.rx_holding_full <= 1'b0;
			r.int_pend <= 1'b0;
			r.irq_req_b <= 1'b1;
			r.rdata <= BYTE_RESET;
			r.state <= ST_IDLE;
			r.edge_cnt <= 5'h00;
			r.tick_cnt <= 3'h0;
			r.byte_end <= 1'b0;
			r.sck <= 1'b0;
			r.ss_b <= SS_IDLE;
		end else begin
			r <= r_nxt;
		end
	end

	// ****************************************************************
	// Outputs, all from flip-flops
	// ****************************************************************
	assign uc_rdata = r.rdata;
	assign irq_req_b = r.irq_req_b;
	assign tx_holding_empty = r.tx_holding_empty;
	assign rx_holding_full = r.rx_holding_full;
	assign sck = r.sck;
	assign ss_b = r.ss_b;

endmodule

/* File: rtl/spi_master_pkg.sv */
// Purpose: shared constants and types of the SPI master control block
// Assumes: 8-bit microcontroller register port, one system clock
// Notes: register offsets are raw port addresses, not word indices

package spi_master_pkg;

	// ****************************************************************
	// Register offsets on the microcontroller port
	// ****************************************************************
	localparam logic [7:0] ADDR_STATUS = 8'h80;
	localparam logic [7:0] ADDR_CONTROL = 8'h84;
	localparam logic [7:0] ADDR_SLAVE_SEL = 8'h88;
	localparam logic [7:0] ADDR_TX_HOLD = 8'h8A;
	localparam logic [7:0] ADDR_RX_HOLD = 8'h8E;

	// ****************************************************************
	// Status bit positions and reset values
	// ****************************************************************
	localparam int STAT_BUSY_BIT = 5;
	localparam int STAT_INT_B_BIT = 4;
	localparam int STAT_TX_EMPTY_BIT = 3;
	localparam int STAT_RX_FULL_BIT = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] SLAVE_SEL_RESET = 8'h00;
	localparam logic [7:0] SS_IDLE = 8'hFF;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ****************************************************************
	// Serial timing, counted in serial clock half periods; divider base in clocks
	// ****************************************************************
	localparam logic [2:0] SEL_TICKS = 3'h2;
	localparam logic [2:0] HOLD_TICKS = 3'h4;
	localparam logic [4:0] BYTE_EDGES = 5'h10;
	localparam logic [4:0] HALF_DIV_BASE = 5'h02;

	// ****************************************************************
	// Types
	// ****************************************************************
	// Control register layout, bit 7 first
	typedef struct packed {
		logic master_enable;
		logic irq_enable;
		logic start;
		logic [1:0] serial_clock_divider;
		logic clock_phase;
		logic clock_polarity;
		logic rx_sample_edge;
	} master_control_s;

	// One microcontroller bus cycle, strobes one clock long
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} uc_req_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SELECT = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_HOLD = 4'b1000
	} xfer_state_e;

	// Last count of a half period: 1, 3, 7 or 15, for 2, 4, 8 or 16 clocks
	function automatic logic [4:0] half_limit(input logic [1:0] div);
		half_limit = (HALF_DIV_BASE << div) - 5'h01;
	endfunction

endpackage

/* File: testbench/spi_master_ctrl_sva.sv */
// Purpose: assertion checker for the SPI master control block
// Assumes: sees only the top module ports
// Notes: bound to the design at the foot of this file
`timescale 1ns/10ps
module spi_master_ctrl_sva
	import spi_master_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input spi_master_pkg::uc_req_s uc_req,
	input wire logic [7:0] uc_rdata,
	input wire logic irq_req_b,
	input wire logic tx_holding_empty,
	input wire logic rx_holding_full,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic [7:0] ss_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the select register, so a frame with no slave picked
	// (all selects left high) is not taken for a missing frame
	logic [7:0] sel_shadow;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sel_shadow <= 8'h00;
		end else if (uc_req.wr && uc_req.addr == ADDR_SLAVE_SEL) begin
			sel_shadow <= uc_req.wdata;
		end
	end
	// ****
	// Register side
	// ****
	tx_write_clear_a: assert property (
		uc_req.wr && uc_req.addr == ADDR_TX_HOLD |=> !tx_holding_empty)
		else $error("tx write left empty flag set");
	status_mirror_a: assert property (
		uc_req.rd && uc_req.addr == ADDR_STATUS |=>
		uc_rdata[3] == $past(tx_holding_empty) &&
		uc_rdata[2] == $past(rx_holding_full))
		else $error("status flags differ from pins");
	unused_zero_a: assert property (
		uc_req.rd && uc_req.addr == ADDR_STATUS |=> uc_rdata[1:0] == 2'h0)
		else $error("unused status bits not zero");
	// Own disable: this one must hold while reset is low
	reset_state_a: assert property (disable iff (1'b0)
		!rst_b |=> tx_holding_empty && !rx_holding_full && !sck &&
		irq_req_b && ss_b == SS_IDLE)
		else $error("reset values wrong");
	// ****
	// Serial side
	// ****
	sck_half_a: assert property (
		ss_b != SS_IDLE && $changed(sck) |=> $stable(sck))
		else $error("serial clock half period too short");
	rx_in_frame_a: assert property (
		$rose(rx_holding_full) && $past(sel_shadow) != 8'h00 |->
		$past(ss_b) != SS_IDLE)
		else $error("receive flag set outside a frame");
	tx_take_a: assert property (
		$rose(tx_holding_empty) && $past(sel_shadow) != 8'h00 |->
		ss_b != SS_IDLE)
		else $error("byte taken without a frame");
	irq_cause_a: assert property (
		$fell(irq_req_b) |-> tx_holding_empty || rx_holding_full)
		else $error("interrupt without a flag cause");
endmodule
bind spi_master_ctrl spi_master_ctrl_sva spi_master_ctrl_sva_i (
	.clk(clk), .rst_b(rst_b), .uc_req(uc_req), .uc_rdata(uc_rdata),
	.irq_req_b(irq_req_b), .tx_holding_empty(tx_holding_empty),
	.rx_holding_full(rx_holding_full), .sck(sck), .mosi(mosi),
	.miso(miso), .ss_b(ss_b));

/* File: testbench/spi_slave_model.sv */
// Purpose: behavioural SPI slave on the far side of the master
// Assumes: mode bits match those written to the master
// Notes: msb first both ways, byte reloaded every eight bits
`timescale 1ns/10ps
module spi_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_b,
	input wire logic cpha,
	input wire logic cpol,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	int cnt;
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		cnt = 0;
	end
	// Phase 0 slave shows its first bit at select
	always @(negedge sel_b) begin
		cnt = 0;
		if (!cpha) begin
			miso = tx_byte[7];
			cnt = 1;
		end
	end
	// Released line must not look like a stale bit
	always @(posedge sel_b) miso = ~miso;
	// Sample on one edge, drive on the other
	always @(sck) begin
		if (!sel_b) begin
			if ((sck != cpol) ^ cpha)
				rx_byte = {rx_byte[6:0], mosi};
			else begin
				miso = tx_byte[7 - cnt];
				cnt = (cnt + 1) % 8;
			end
		end
	end
endmodule

/* File: testbench/test_spi_master_ctrl.sv */
// Purpose: self-checking bench of the SPI master control block
// Assumes: inputs change on the falling clock edge
// Notes: one byte per mode and divider, then an abort mid-frame
`timescale 1ns/10ps
module test_spi_master_ctrl;
	import spi_master_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	uc_req_s uc_req = '0;
	logic [7:0] uc_rdata, ss_b, slv_rx, got, tx, ctl;
	logic irq_req_b, tx_holding_empty, rx_holding_full, sck, mosi, miso;
	logic cpha = 1'b0;
	logic cpol = 1'b0;
	logic sck_last = 1'b0;
	logic [7:0] slv_tx = 8'h00;
	int fails = 0;
	int comparisons = 0;
	int tog = 0;
	int cyc = 0;
	int t1 = 0;
	int gap = 0;

	always #20 clk = ~clk;

	spi_master_ctrl spi_master_ctrl_i (.clk(clk), .rst_b(rst_b),
		.uc_req(uc_req), .uc_rdata(uc_rdata), .irq_req_b(irq_req_b),
		.tx_holding_empty(tx_holding_empty),
		.rx_holding_full(rx_holding_full), .sck(sck), .mosi(mosi),
		.miso(miso), .ss_b(ss_b));
	spi_slave_model spi_slave_model_i (.sck(sck), .mosi(mosi),
		.sel_b(ss_b[0]), .cpha(cpha), .cpol(cpol), .tx_byte(slv_tx),
		.miso(miso), .rx_byte(slv_rx));

	// ****
	// Helpers
	// ****
	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, gv);
		comparisons++;
		if (gv !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, gv);
			fails++;
		end
	endtask
	// Read data sampled two edges on: safe for either update edge
	task automatic bus(input logic wr, input logic [7:0] a, d);
		@(negedge clk);
		uc_req = '{a, d, wr, !wr};
		@(negedge clk);
		uc_req.wr = 1'b0;
		uc_req.rd = 1'b0;
		@(negedge clk);
		got = uc_rdata;
	endtask
	function automatic logic sig(input int which);
		case (which)
			0: return tx_holding_empty;
			1: return rx_holding_full;
			default: return &ss_b;
		endcase
	endfunction
	function automatic logic [7:0] half(input logic [1:0] d);
		return 8'h02 << d;
	endfunction
	task automatic wait_for(input int which, input logic v);
		int n;
		n = 0;
		while (sig(which) !== v) begin
			@(negedge clk);
			n++;
			if (n > 4000) begin
				$display("CHECK FAILED wait %0d expected %h seen none",
					which, v);
				fails++;
				conclude();
			end
		end
	endtask

	// Serial clock edge count and first half period of a frame
	always @(negedge clk) begin
		if (ss_b != SS_IDLE && sck !== sck_last) begin
			if (tog == 0)
				t1 = cyc;
			if (tog == 1)
				gap = cyc - t1;
			tog++;
		end
		sck_last = sck;
		cyc++;
	end

	// ****
	// Main sequence
	// ****
	initial begin
		void'($urandom(32'h19d0b167));
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		bus(0, ADDR_STATUS, 8'h00);
		chk("status", 8'h18, got);
		bus(0, ADDR_CONTROL, 8'h00);
		chk("control", 8'h00, got);
		bus(0, 8'h90, 8'h00);
		chk("unmapped", 8'h00, got);
		$display("test reset done");
		// Every mode and divider; last pass masks the interrupt
		for (int i = 0; i < 4; i++) begin
			cpha = i[0];
			cpol = i[1];
			slv_tx = 8'($urandom);
			tx = (i == 0) ? 8'h80 : 8'($urandom);
			// Mode 0 reads the same bits on either edge: sample bit drawn
			ctl = {1'b1, i != 3, 1'b1, 2'(i), cpha, cpol,
				(i == 0) ? 1'($urandom) : (cpha == cpol)};
			bus(1, ADDR_SLAVE_SEL, 8'h01);
			bus(0, ADDR_SLAVE_SEL, 8'h00);
			chk("slave_sel", 8'h01, got);
			bus(1, ADDR_TX_HOLD, tx);
			chk("tx_empty", 8'h00, {7'h0, tx_holding_empty});
			bus(0, ADDR_TX_HOLD, 8'h00);
			chk("tx_hold", tx, got);
			tog = 0;
			bus(1, ADDR_CONTROL, ctl);
			wait_for(0, 1'b1);
			repeat (2) @(negedge clk);
			chk("irq", {7'h0, i == 3}, {7'h0, irq_req_b});
			bus(0, ADDR_STATUS, 8'h00);
			chk("pending", 8'h00, got & 8'h10);
			// Read of the empty receive register only drops the cause
			bus(0, ADDR_RX_HOLD, 8'h00);
			chk("irq_drop", 8'h01, {7'h0, irq_req_b});
			ctl[5] = 1'b0;
			bus(1, ADDR_CONTROL, ctl);
			bus(0, ADDR_CONTROL, 8'h00);
			chk("control_rb", ctl, got);
			wait_for(1, 1'b1);
			chk("irq_rx", {7'h0, i == 3}, {7'h0, irq_req_b});
			bus(0, ADDR_RX_HOLD, 8'h00);
			chk("rx_byte", slv_tx, got);
			chk("rx_full", 8'h00, {7'h0, rx_holding_full});
			chk("irq_clear", 8'h01, {7'h0, irq_req_b});
			wait_for(2, 1'b1);
			chk("slave_rx", tx, slv_rx);
			chk("idle_sck", {7'h0, cpol}, {7'h0, sck});
			chk("edges", 8'h10, 8'(tog));
			chk("half", half(2'(i)), 8'(gap));
			$display("test mode %0d done", i);
		end
		// Disable in mid-frame idles the bus at once
		bus(1, ADDR_TX_HOLD, 8'hA5);
		bus(1, ADDR_CONTROL, 8'hA8);
		repeat (20) @(negedge clk);
		chk("abort_busy", 8'h00, {7'h0, &ss_b});
		bus(1, ADDR_CONTROL, 8'h00);
		chk("abort_ss", SS_IDLE, ss_b);
		chk("abort_sck", 8'h00, {7'h0, sck});
		$display("test abort done");
		conclude();
	end
endmodule
